// ===== hdl/sic_core.sv
// Special register core: indirect ports, pointers, working register, pc low byte, flags.
`timescale 1ns/1ps
`include "sic_defines.svh"
module sic_core
  import sic_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    clk_en_in,
  input  wire logic                    op_valid_in,
  input  wire sic_op_t                 op_code_in,
  input  wire logic [`SIC_ADDR_W-1:0]  addr_in,
  input  wire logic                    dest_mem_in,
  input  wire logic                    wdt_timeout_in,
  output logic                         op_ready_out,
  output logic                         op_done_out,
  output logic [7:0]                   rd_data_out,
  output logic [7:0]                   working_register_out,
  output logic [7:0]                   flags_register_out,
  output logic [`SIC_PC_W-1:0]         pc_out,
  output logic                         dummy_cycle_out
);

  // True when an address names one of the two indirect ports.
  function automatic logic is_port(input logic [`SIC_ADDR_W-1:0] a);
    is_port = (a == `SIC_OFS_PORT0) || (a == `SIC_OFS_PORT1);
  endfunction : is_port

  // Architectural state.
  sic_state_t                 state;
  logic [`SIC_ADDR_W-1:0]     mem_pointer_zero;
  logic [`SIC_ADDR_W-1:0]     mem_pointer_one;
  logic                       bank_select;
  logic [7:0]                 working_register;
  logic [`SIC_PC_W-1:0]       pc;
  logic [3:0]                 arith_flags;
  logic                       watchdog_expired_flag;
  logic                       sleep_entered_flag;
  logic [7:0]                 gpr_mem [0:`SIC_MEM_DEPTH-1];

  // Next values.
  sic_state_t                 next_state;
  logic [`SIC_ADDR_W-1:0]     next_ptr0;
  logic [`SIC_ADDR_W-1:0]     next_ptr1;
  logic                       next_bank;
  logic [7:0]                 next_wreg;
  logic [`SIC_PC_W-1:0]       next_pc;
  logic [3:0]                 next_arith;
  logic                       next_to;
  logic                       next_pdf;

  // An operation is taken only while the sequencer runs and the clock is enabled.
  wire take = clk_en_in && op_valid_in && (state == SIC_ST_RUN);

  // Decode of the operation class.
  wire op_load  = (op_code_in == SIC_OP_LOAD);
  wire op_store = (op_code_in == SIC_OP_STORE);
  wire op_kick  = (op_code_in == SIC_OP_KICK);
  wire op_sleep = (op_code_in == SIC_OP_SLEEP);
  wire op_alu   = !(op_load || op_store || op_kick || op_sleep ||
                    (op_code_in == SIC_OP_NOP));

  // Effective address: a port redirects to its pointer, direct access stays in bank 0.
  wire                    via_port0 = (addr_in == `SIC_OFS_PORT0);
  wire                    via_port1 = (addr_in == `SIC_OFS_PORT1);
  wire [`SIC_ADDR_W-1:0]  eff_addr  = via_port0 ? mem_pointer_zero :
                                      via_port1 ? mem_pointer_one  :
                                      addr_in;
  wire                    eff_bank  = via_port1 ? bank_select : 1'b0;

  // A pointer that names a port itself gives a dead access.
  wire self_ref = (via_port0 || via_port1) && is_port(eff_addr);

  // Special registers occupy the low half and are shared by both banks.
  wire                    gpr_hit  = eff_addr[`SIC_GPR_BIT];
  wire [6:0]              gpr_idx  = {eff_bank, eff_addr[5:0]};

  // Flag register as software sees it; the top two bits are unimplemented.
  wire [7:0] flags_view = {2'b00, watchdog_expired_flag, sleep_entered_flag,
                           arith_flags};

  // Special register read mux; anything unlisted is unused or reserved.
  logic [7:0] sfr_rd;
  always_comb
  begin
    unique case (eff_addr)
      `SIC_OFS_PTR0:  sfr_rd = {1'b1, mem_pointer_zero};
      `SIC_OFS_PTR1:  sfr_rd = {1'b1, mem_pointer_one};
      `SIC_OFS_BANK:  sfr_rd = {7'h00, bank_select};
      `SIC_OFS_WREG:  sfr_rd = working_register;
      `SIC_OFS_PCLOW: sfr_rd = pc[7:0];
      `SIC_OFS_FLAGS: sfr_rd = flags_view;
      default:        sfr_rd = 8'h00;
    endcase
  end

  // Operand value seen by the execution core.
  wire [7:0] rd_val = self_ref ? 8'h00 :
                      gpr_hit  ? gpr_mem[gpr_idx] : sfr_rd;

  // Arithmetic unit: working register is one operand, memory the other.
  logic [7:0] alu_result;
  logic       alu_c;
  logic       alu_ac;
  logic       alu_ov;
  logic       alu_z;
  logic       alu_upd_arith;
  logic       alu_upd_c;
  logic       alu_upd_z;

  sic_alu u_alu (
    .op_in         (op_code_in),
    .a_in          (working_register),
    .b_in          (rd_val),
    .c_in          (arith_flags[`SIC_FLAG_C]),
    .result_out    (alu_result),
    .c_out         (alu_c),
    .ac_out        (alu_ac),
    .ov_out        (alu_ov),
    .z_out         (alu_z),
    .upd_arith_out (alu_upd_arith),
    .upd_c_out     (alu_upd_c),
    .upd_z_out     (alu_upd_z)
  );

  // Memory is written only from the working register or from a unit result,
  // so there is no path that copies one location straight into another.
  wire        alu_to_mem = op_alu && dest_mem_in;
  wire [7:0]  wr_val     = op_store ? working_register : alu_result;
  wire        wr_any     = take && (op_store || alu_to_mem) && !self_ref;
  wire        wr_gpr     = wr_any && gpr_hit;
  wire        wr_sfr     = wr_any && !gpr_hit;

  // Individual special register write strobes.
  wire wr_ptr0  = wr_sfr && (eff_addr == `SIC_OFS_PTR0);
  wire wr_ptr1  = wr_sfr && (eff_addr == `SIC_OFS_PTR1);
  wire wr_bank  = wr_sfr && (eff_addr == `SIC_OFS_BANK);
  wire wr_wreg  = wr_sfr && (eff_addr == `SIC_OFS_WREG);
  wire wr_pcl   = wr_sfr && (eff_addr == `SIC_OFS_PCLOW);
  wire wr_flags = wr_sfr && (eff_addr == `SIC_OFS_FLAGS);

  // Working register takes loads and unit results aimed at it.
  wire wreg_from_alu = take && op_alu && !dest_mem_in;
  wire wreg_from_mem = take && op_load;

  // Pointer and bank register updates; the pointer top bit is not stored.
  always_comb
  begin
    next_ptr0 = wr_ptr0 ? wr_val[`SIC_ADDR_W-1:0] : mem_pointer_zero;
    next_ptr1 = wr_ptr1 ? wr_val[`SIC_ADDR_W-1:0] : mem_pointer_one;
    next_bank = wr_bank ? wr_val[0] : bank_select;
  end

  // Working register update; a store aimed at itself writes its own value back.
  always_comb
  begin
    next_wreg = working_register;
    if (wreg_from_mem)
      next_wreg = rd_val;
    else if (wreg_from_alu)
      next_wreg = alu_result;
    else if (wr_wreg)
      next_wreg = wr_val;
  end

  // Program counter: each instruction steps it, a low-byte write replaces the
  // low byte only, and the sequencer then spends one dummy cycle.
  always_comb
  begin
    next_pc    = pc;
    next_state = state;
    unique case (state)
      SIC_ST_RUN:
      begin
        if (take && wr_pcl)
        begin
          next_pc    = {pc[`SIC_PC_W-1:8], wr_val};
          next_state = SIC_ST_DUMMY;
        end
        else if (take)
          next_pc = pc + `SIC_PC_W'(1);
      end
      SIC_ST_DUMMY:
        next_state = SIC_ST_RUN;
      default:
        next_state = SIC_ST_RUN;
    endcase
  end

  // Arithmetic flags: a data write touches bits 0 to 3 only; the unit's own
  // flag updates win over a written value when it writes the flag register.
  always_comb
  begin
    next_arith = arith_flags;
    if (wr_flags)
      next_arith = wr_val[3:0] & `SIC_FLAGS_WMASK;
    if (take && op_alu && alu_upd_arith)
    begin
      next_arith[`SIC_FLAG_C]  = alu_c;
      next_arith[`SIC_FLAG_AC] = alu_ac;
      next_arith[`SIC_FLAG_OV] = alu_ov;
    end
    if (take && op_alu && alu_upd_c)
      next_arith[`SIC_FLAG_C] = alu_c;
    if (take && op_alu && alu_upd_z)
      next_arith[`SIC_FLAG_Z] = alu_z;
  end

  // System flags ignore data writes. A time-out in the same cycle as a kick or
  // sleep still sets the watchdog flag so that the event is never lost.
  always_comb
  begin
    next_to  = watchdog_expired_flag;
    next_pdf = sleep_entered_flag;
    if (take && (op_kick || op_sleep))
      next_to = 1'b0;
    if (wdt_timeout_in)
      next_to = 1'b1;
    if (take && op_kick)
      next_pdf = 1'b0;
    if (take && op_sleep)
      next_pdf = 1'b1;
  end

  // Sequencer and program counter.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= SIC_ST_RUN;
      pc    <= `SIC_PC_RESET;
    end
    else if (clk_en_in)
    begin
      state <= next_state;
      pc    <= next_pc;
    end
  end

  // Pointer registers and bank select.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mem_pointer_zero <= `SIC_PTR_RESET;
      mem_pointer_one  <= `SIC_PTR_RESET;
      bank_select      <= 1'b0;
    end
    else if (clk_en_in)
    begin
      mem_pointer_zero <= next_ptr0;
      mem_pointer_one  <= next_ptr1;
      bank_select      <= next_bank;
    end
  end

  // Working register and arithmetic flags get a fixed reset value for
  // determinism, though software may not count on it.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      working_register <= `SIC_WREG_RESET;
      arith_flags      <= `SIC_ARITH_RESET;
    end
    else if (clk_en_in)
    begin
      working_register <= next_wreg;
      arith_flags      <= next_arith;
    end
  end

  // Power-up clears both system flags.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      watchdog_expired_flag <= 1'b0;
      sleep_entered_flag    <= 1'b0;
    end
    else if (clk_en_in)
    begin
      watchdog_expired_flag <= next_to;
      sleep_entered_flag    <= next_pdf;
    end
  end

  // General purpose memory holds no reset value, as in the real array.
  always_ff @(posedge clk_in)
  begin
    if (clk_en_in && wr_gpr)
      gpr_mem[gpr_idx] <= wr_val;
  end

  // Registered outputs toward the execution core. Flag state is exposed but
  // never pushed anywhere on calls or interrupt entry; software must save it.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      op_ready_out         <= 1'b1;
      op_done_out          <= 1'b0;
      rd_data_out          <= 8'h00;
      working_register_out <= `SIC_WREG_RESET;
      flags_register_out   <= 8'h00;
      pc_out               <= `SIC_PC_RESET;
      dummy_cycle_out      <= 1'b0;
    end
    else if (clk_en_in)
    begin
      op_ready_out         <= (next_state == SIC_ST_RUN);
      op_done_out          <= take;
      if (take && (op_load || op_alu))
        rd_data_out <= rd_val;
      working_register_out <= next_wreg;
      flags_register_out   <= {2'b00, next_to, next_pdf, next_arith};
      pc_out               <= next_pc;
      dummy_cycle_out      <= (next_state == SIC_ST_DUMMY);
    end
  end

endmodule : sic_core

// ===== hdl/sic_defines.svh
// Offsets, field positions, reset values and sizes of the register core.
`ifndef SIC_DEFINES_SVH
`define SIC_DEFINES_SVH

`define SIC_ADDR_W      7
`define SIC_PC_W        13
`define SIC_BANK_DEPTH  64
`define SIC_MEM_DEPTH   128

`define SIC_OFS_PORT0   7'h00
`define SIC_OFS_PTR0    7'h01
`define SIC_OFS_PORT1   7'h02
`define SIC_OFS_PTR1    7'h03
`define SIC_OFS_BANK    7'h04
`define SIC_OFS_WREG    7'h05
`define SIC_OFS_PCLOW   7'h06
`define SIC_OFS_FLAGS   7'h0A
`define SIC_GPR_BIT     6

`define SIC_FLAG_C      0
`define SIC_FLAG_AC     1
`define SIC_FLAG_Z      2
`define SIC_FLAG_OV     3
`define SIC_FLAG_PDF    4
`define SIC_FLAG_TO     5
`define SIC_FLAGS_WMASK 4'hF

`define SIC_PC_RESET    13'h0000
`define SIC_PTR_RESET   7'h00
`define SIC_ARITH_RESET 4'h0
`define SIC_WREG_RESET  8'h00

`endif

// ===== hdl/sic_pkg.sv
// Types shared by the register core and its arithmetic unit.
package sic_pkg;

  // Operations issued by the execution core.
  typedef enum logic [3:0] {
    SIC_OP_NOP   = 4'h0,
    SIC_OP_LOAD  = 4'h1,
    SIC_OP_STORE = 4'h2,
    SIC_OP_ADD   = 4'h3,
    SIC_OP_SUB   = 4'h4,
    SIC_OP_AND   = 4'h5,
    SIC_OP_OR    = 4'h6,
    SIC_OP_XOR   = 4'h7,
    SIC_OP_INC   = 4'h8,
    SIC_OP_DEC   = 4'h9,
    SIC_OP_CPL   = 4'hA,
    SIC_OP_CLR   = 4'hB,
    SIC_OP_RLC   = 4'hC,
    SIC_OP_RRC   = 4'hD,
    SIC_OP_KICK  = 4'hE,
    SIC_OP_SLEEP = 4'hF
  } sic_op_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    SIC_ST_RUN   = 2'b01,
    SIC_ST_DUMMY = 2'b10
  } sic_state_t;

endpackage : sic_pkg

// ===== hdl/sic_alu.sv
// Arithmetic and logic unit that produces a result and its flag updates.
`timescale 1ns/1ps
module sic_alu
  import sic_pkg::*;
(
  input  wire sic_op_t     op_in,
  input  wire logic [7:0]  a_in,
  input  wire logic [7:0]  b_in,
  input  wire logic        c_in,
  output logic [7:0]       result_out,
  output logic             c_out,
  output logic             ac_out,
  output logic             ov_out,
  output logic             z_out,
  output logic             upd_arith_out,
  output logic             upd_c_out,
  output logic             upd_z_out
);

  // Nine-bit sum with carry in, reused for the nibble and seven-bit carries.
  function automatic logic [8:0] add9(input logic [7:0] x, input logic [7:0] y,
                                      input logic ci);
    add9 = {1'b0, x} + {1'b0, y} + {8'h00, ci};
  endfunction : add9

  // Subtraction is addition of the inverted operand plus one, so carry means no borrow.
  wire        is_sub  = (op_in == SIC_OP_SUB);
  wire [7:0]  addend  = is_sub ? ~b_in : b_in;
  wire [8:0]  sum     = add9(a_in, addend, is_sub);
  wire [8:0]  low_sum = add9(a_in & 8'h0F, addend & 8'h0F, is_sub);
  wire [8:0]  sev_sum = add9(a_in & 8'h7F, addend & 8'h7F, is_sub);

  // Result selection and which flags the operation touches.
  always_comb
  begin
    result_out    = 8'h00;
    c_out         = sum[8];
    ac_out        = low_sum[4];
    ov_out        = sev_sum[7] ^ sum[8];
    upd_arith_out = 1'b0;
    upd_c_out     = 1'b0;
    upd_z_out     = 1'b1;
    unique case (op_in)
      SIC_OP_ADD, SIC_OP_SUB:
      begin
        result_out    = sum[7:0];
        upd_arith_out = 1'b1;
      end
      SIC_OP_AND: result_out = a_in & b_in;
      SIC_OP_OR:  result_out = a_in | b_in;
      SIC_OP_XOR: result_out = a_in ^ b_in;
      SIC_OP_INC: result_out = b_in + 8'h01;
      SIC_OP_DEC: result_out = b_in - 8'h01;
      SIC_OP_CPL: result_out = ~b_in;
      SIC_OP_RLC:
      begin
        result_out = {b_in[6:0], c_in};
        c_out      = b_in[7];
        upd_c_out  = 1'b1;
        upd_z_out  = 1'b0;
      end
      SIC_OP_RRC:
      begin
        result_out = {c_in, b_in[7:1]};
        c_out      = b_in[0];
        upd_c_out  = 1'b1;
        upd_z_out  = 1'b0;
      end
      default: upd_z_out = 1'b0;
    endcase
  end

  assign z_out = (result_out == 8'h00);

endmodule : sic_alu

// ===== test/sic_exec_model.sv
// Behavioural model of the execution core that issues operations to the register core.
`timescale 1ns/1ps
module sic_exec_model
  import sic_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        op_ready_in,
  output logic             clk_en_out,
  output logic             op_valid_out,
  output sic_op_t          op_code_out,
  output logic [6:0]       addr_out,
  output logic             dest_mem_out,
  output logic             wdt_timeout_out
);
  // Everything starts idle; the clock enable stays high for the whole run except the one cycle that frozen_wdt drives it low.
  initial
  begin
    clk_en_out      = 1'b1;
    op_valid_out    = 1'b0;
    op_code_out     = SIC_OP_NOP;
    addr_out        = 7'h00;
    dest_mem_out    = 1'b0;
    wdt_timeout_out = 1'b0;
  end

  // Holds the request until an edge that sees ready high, then scrambles the address
  // so that a stale value can never pass for a fresh one. Bank 1 is reached only by
  // callers that go through pointer one and its port.
  // A request that never sees ready high hangs here on purpose, so that the bench watchdog
  // counts it as a failure instead of the request being dropped silently.
  task automatic issue(input sic_op_t op, input logic [6:0] a, input logic d,
                       input int idle = 0);
    repeat (idle + 1) @(posedge clk_in);
    op_valid_out <= 1'b1;
    op_code_out  <= op;
    addr_out     <= a;
    dest_mem_out <= d;
    do
    begin
      @(posedge clk_in);
    end
    while (op_ready_in !== 1'b1);
    op_valid_out <= 1'b0;
    addr_out     <= ~a;
    #1;
  endtask : issue

  // One enabled cycle of watchdog time-out.
  task automatic pulse_wdt();
    @(posedge clk_in);
    wdt_timeout_out <= 1'b1;
    @(posedge clk_in);
    wdt_timeout_out <= 1'b0;
    #1;
  endtask : pulse_wdt

  // One time-out presented while the clock enable is low; a frozen core must lose it.
  task automatic frozen_wdt();
    @(posedge clk_in);
    clk_en_out      <= 1'b0;
    wdt_timeout_out <= 1'b1;
    @(posedge clk_in);
    clk_en_out      <= 1'b1;
    wdt_timeout_out <= 1'b0;
    #1;
  endtask : frozen_wdt
endmodule : sic_exec_model

// ===== test/sic_core_props.sv
// Port-level assertions for the register core.
`timescale 1ns/1ps
`include "sic_defines.svh"
module sic_core_props
  import sic_pkg::*;
(
  input wire logic                   clk_in,
  input wire logic                   rst_in,
  input wire logic                   clk_en_in,
  input wire logic                   op_valid_in,
  input wire sic_op_t                op_code_in,
  input wire logic [`SIC_ADDR_W-1:0] addr_in,
  input wire logic                   dest_mem_in,
  input wire logic                   wdt_timeout_in,
  input wire logic                   op_ready_out,
  input wire logic                   op_done_out,
  input wire logic [7:0]             rd_data_out,
  input wire logic [7:0]             working_register_out,
  input wire logic [7:0]             flags_register_out,
  input wire logic [`SIC_PC_W-1:0]   pc_out,
  input wire logic                   dummy_cycle_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // An operation is taken only on an enabled edge with ready high.
  wire take     = op_valid_in && op_ready_out && clk_en_in;
  wire take_add = take && op_code_in == SIC_OP_ADD && !dest_mem_in;
  wire sys_op   = take && (op_code_in == SIC_OP_KICK || op_code_in == SIC_OP_SLEEP);

  // A pc low-byte write is a jump, then one dead cycle, then normal running.
  sequence s_pcw_take;
    take && op_code_in == SIC_OP_STORE && addr_in == `SIC_OFS_PCLOW;
  endsequence
  sequence s_jump_dead;
    dummy_cycle_out && !op_ready_out &&
    pc_out == {$past(pc_out[12:8]), $past(working_register_out)};
  endsequence
  sequence s_back_to_run;
    !dummy_cycle_out && op_ready_out;
  endsequence

  a_pc_jump: assert property (s_pcw_take |=> s_jump_dead)
    else $error("pc low-byte write did not jump in page with a dead cycle");
  a_dummy_ends: assert property (dummy_cycle_out && clk_en_in |=> s_back_to_run)
    else $error("dead cycle lasted more than one cycle");
  a_done_pulse: assert property (take |=> op_done_out)
    else $error("taken operation gave no done pulse");
  a_no_stray_done: assert property (clk_en_in && !take |=> !op_done_out)
    else $error("done pulse without a taken operation");
  a_top_bits_zero: assert property (flags_register_out[7:6] == 2'b00)
    else $error("unimplemented flag bits read nonzero");
  a_timeout_sets: assert property (clk_en_in && wdt_timeout_in |=> flags_register_out[5])
    else $error("time-out did not set the watchdog flag");
  a_sleep_sets: assert property (sys_op && op_code_in == SIC_OP_SLEEP && !wdt_timeout_in
    |=> flags_register_out[5:4] == 2'b01)
    else $error("sleep did not set sleep flag and clear watchdog flag");
  a_kick_clears: assert property (sys_op && op_code_in == SIC_OP_KICK && !wdt_timeout_in
    |=> flags_register_out[5:4] == 2'b00)
    else $error("kick did not clear both system flags");
  a_sys_flags_held: assert property (clk_en_in && !wdt_timeout_in && !sys_op
    |=> $stable(flags_register_out[5:4]))
    else $error("system flags moved without a system event");
  a_add_zero: assert property (take_add
    |=> flags_register_out[2] == (working_register_out == 8'h00))
    else $error("zero flag wrong after add");
  a_add_carry: assert property (take_add |=> flags_register_out[0] ==
    (({1'b0, $past(working_register_out)} + {1'b0, rd_data_out}) > 9'h0FF))
    else $error("carry flag wrong after add");
endmodule : sic_core_props

// ===== test/sic_core_test.sv
// Self-checking testbench of the register core with the execution-core model.
`timescale 1ns/1ps
module sic_core_test;
  import sic_pkg::*;
  localparam logic [6:0] SCR = 7'h7F;

  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        clk_en, op_valid, dest_mem, wdt_timeout;
  sic_op_t     op_code;
  logic [6:0]  addr;
  logic        op_ready, op_done, dummy;
  logic [7:0]  rd_data, wreg, flags;
  logic [12:0] pc;
  int          num_errors = 0;
  int          n_checks   = 0;

  // 200 MHz clock.
  always #2.5 clk_in = ~clk_in;

  sic_exec_model u_exec (.clk_in(clk_in), .op_ready_in(op_ready), .clk_en_out(clk_en),
    .op_valid_out(op_valid), .op_code_out(op_code), .addr_out(addr),
    .dest_mem_out(dest_mem), .wdt_timeout_out(wdt_timeout));

  sic_core u_dut (.clk_in(clk_in), .rst_in(rst_in), .clk_en_in(clk_en),
    .op_valid_in(op_valid), .op_code_in(op_code), .addr_in(addr), .dest_mem_in(dest_mem),
    .wdt_timeout_in(wdt_timeout), .op_ready_out(op_ready), .op_done_out(op_done),
    .rd_data_out(rd_data), .working_register_out(wreg), .flags_register_out(flags),
    .pc_out(pc), .dummy_cycle_out(dummy));

  // Compares one byte and reports a mismatch at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic op_w(input sic_op_t o, input logic [6:0] a);
    u_exec.issue(o, a, 1'b0);
  endtask : op_w

  // Builds any working-register value by clear, doubling and increments via scratch.
  task automatic make_w(input logic [7:0] v);
    op_w(SIC_OP_CLR, 7'h07);
    for (int i = 7; i >= 0; i--)
    begin
      op_w(SIC_OP_STORE, SCR);
      op_w(SIC_OP_ADD, SCR);
      if (v[i])
      begin
        op_w(SIC_OP_STORE, SCR);
        op_w(SIC_OP_INC, SCR);
      end
    end
  endtask : make_w

  // Unused and reserved locations read zero and ignore writes.
  task automatic test_unused();
    make_w(8'h5A);
    op_w(SIC_OP_STORE, 7'h08);
    op_w(SIC_OP_LOAD, 7'h08);
    check(rd_data, 8'h00);
    op_w(SIC_OP_LOAD, 7'h3F);
    check(rd_data, 8'h00);
  endtask : test_unused

  // Both pointer paths, bank reach, pointer bit 7 and the mirrored special registers.
  task automatic test_indirect();
    make_w(8'h40);
    op_w(SIC_OP_STORE, 7'h01);
    make_w(8'hA5);
    op_w(SIC_OP_STORE, 7'h00);
    op_w(SIC_OP_LOAD, 7'h40);
    check(rd_data, 8'hA5);
    op_w(SIC_OP_LOAD, 7'h01);
    check(rd_data, 8'hC0);
    make_w(8'h01);
    op_w(SIC_OP_STORE, 7'h04);
    make_w(8'h40);
    op_w(SIC_OP_STORE, 7'h03);
    make_w(8'h3C);
    op_w(SIC_OP_STORE, 7'h02);
    op_w(SIC_OP_LOAD, 7'h02);
    check(rd_data, 8'h3C);
    op_w(SIC_OP_LOAD, 7'h40);
    check(rd_data, 8'hA5);
    op_w(SIC_OP_LOAD, 7'h00);
    check(rd_data, 8'hA5);
    make_w(8'h05);
    op_w(SIC_OP_STORE, 7'h03);
    op_w(SIC_OP_LOAD, 7'h02);
    check(rd_data, 8'h05);
    make_w(8'h00);
    op_w(SIC_OP_STORE, 7'h04);
  endtask : test_indirect

  // Pointers aimed at the ports themselves read zero.
  task automatic test_self_point();
    make_w(8'h00);
    op_w(SIC_OP_STORE, 7'h01);
    op_w(SIC_OP_LOAD, 7'h00);
    check(rd_data, 8'h00);
    make_w(8'h02);
    op_w(SIC_OP_STORE, 7'h03);
    op_w(SIC_OP_LOAD, 7'h02);
    check(rd_data, 8'h00);
  endtask : test_self_point

  // Adds or subtracts one operand in memory to or from a built working value and checks the low flags.
  task automatic add_case(input sic_op_t o, input logic [7:0] m, input logic [7:0] w,
                          input logic [7:0] res, input logic [3:0] fl);
    make_w(m);
    op_w(SIC_OP_STORE, 7'h41);
    make_w(w);
    op_w(o, 7'h41);
    check(wreg, res);
    check({4'h0, flags[3:0]}, {4'h0, fl});
  endtask : add_case

  task automatic test_arith();
    add_case(SIC_OP_ADD, 8'hFF, 8'h01, 8'h00, 4'h7);
    add_case(SIC_OP_ADD, 8'h80, 8'h80, 8'h00, 4'hD);
    add_case(SIC_OP_ADD, 8'h7F, 8'h01, 8'h80, 4'hA);
    add_case(SIC_OP_SUB, 8'hFF, 8'hFF, 8'h00, 4'h7);
    make_w(8'h01);
    op_w(SIC_OP_STORE, 7'h45);
    op_w(SIC_OP_RRC, 7'h45);
    check({7'h00, flags[0]}, 8'h01);
    op_w(SIC_OP_RLC, 7'h45);
    check({7'h00, flags[0]}, 8'h00);
  endtask : test_arith

  // Watchdog and sleep flags against data writes, sleep and kick.
  task automatic test_sys_flags();
    u_exec.pulse_wdt();
    check({2'b00, flags[5:0]} & 8'h20, 8'h20);
    make_w(8'h00);
    op_w(SIC_OP_STORE, 7'h0A);
    check(flags, 8'h20);
    op_w(SIC_OP_SLEEP, 7'h00);
    check({6'h00, flags[5:4]}, 8'h01);
    make_w(8'hFF);
    op_w(SIC_OP_STORE, 7'h0A);
    check(flags, 8'h1F);
    op_w(SIC_OP_KICK, 7'h00);
    check({6'h00, flags[5:4]}, 8'h00);
    u_exec.frozen_wdt();
    check({7'h00, flags[5]}, 8'h00);
  endtask : test_sys_flags

  // A pc low-byte write jumps within the page and costs one dead cycle.
  task automatic test_pc_low();
    logic [12:0] p;
    make_w(8'h9C);
    p = pc;
    u_exec.issue(SIC_OP_STORE, 7'h06, 1'b0, 2);
    check(pc[7:0], 8'h9C);
    check({3'b000, pc[12:8]}, {3'b000, p[12:8]});
    check({6'h00, dummy, op_ready}, 8'h02);
    @(posedge clk_in);
    #1;
    check({6'h00, dummy, op_ready}, 8'h01);
  endtask : test_pc_low

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Main sequence after ten cycles of reset.
  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    test_unused();
    test_indirect();
    test_self_point();
    test_arith();
    test_sys_flags();
    test_pc_low();
    complete_run();
  end

  // The run needs about eleven hundred cycles; this limit only cuts a hang short.
  initial
  begin
    repeat (60000) @(posedge clk_in);
    num_errors++;
    complete_run();
  end
endmodule : sic_core_test

bind sic_core sic_core_props u_props (.clk_in(clk_in), .rst_in(rst_in),
  .clk_en_in(clk_en_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in),
  .addr_in(addr_in), .dest_mem_in(dest_mem_in), .wdt_timeout_in(wdt_timeout_in),
  .op_ready_out(op_ready_out), .op_done_out(op_done_out), .rd_data_out(rd_data_out),
  .working_register_out(working_register_out), .flags_register_out(flags_register_out),
  .pc_out(pc_out), .dummy_cycle_out(dummy_cycle_out));
